//--- hdl/lrc_pkg.sv
// Shared constants, types and decode function for the LCD command port.
// Assumes a single 20 MHz core clock; no other block shares the package.
package lrc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int BUSY_NS       = 500;
    localparam int BUSY_CYC      =
        (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W         = 4;

    // ------------------------------------------------------------------
    // Instruction codes and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] ONOFF_CODE = 8'h3E;
    localparam logic [7:0] ONOFF_MASK = 8'hFE;
    localparam logic [7:0] LINE_CODE  = 8'hC0;
    localparam logic [7:0] LINE_MASK  = 8'hC0;
    localparam logic [7:0] PAGE_CODE  = 8'hB8;
    localparam logic [7:0] PAGE_MASK  = 8'hF8;
    localparam logic [7:0] COL_CODE   = 8'h40;
    localparam logic [7:0] COL_MASK   = 8'hC0;

    // ------------------------------------------------------------------
    // Status layout and reset values
    // ------------------------------------------------------------------
    localparam int         ST_BUSY_BIT  = 7;
    localparam int         ST_OFF_BIT   = 5;
    localparam int         ST_RESET_BIT = 4;
    localparam logic       DISP_EN_RST  = 1'h0;
    localparam logic [5:0] LINE_RST     = 6'h00;
    localparam logic [2:0] PAGE_RST     = 3'h0;
    localparam logic [5:0] COL_RST      = 6'h00;
    localparam logic [7:0] STATUS_RST   = 8'h20;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'h1,
        PH_EXEC = 2'h2
    } lrc_phase_e;

    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_ONOFF = 3'h1,
        OP_LINE  = 3'h2,
        OP_PAGE  = 3'h3,
        OP_COL   = 3'h4
    } lrc_op_e;

    typedef struct packed {
        logic       display_enable_reg;
        logic [5:0] first_line_reg;
        logic [2:0] page_pointer_reg;
        logic [5:0] column_pointer_reg;
    } lrc_disp_s;

    typedef struct packed {
        logic       sel;
        logic       cmd_data_sel;
        logic       read_nwrite;
        logic [7:0] data;
    } lrc_cap_s;

    typedef struct packed {
        lrc_phase_e phase;
        logic       e_prev;
        lrc_cap_s   cap;
        lrc_disp_s  disp;
        logic [7:0] controller_condition_reg;
        logic [7:0] dout;
        logic       doe;
    } lrc_state_s;

    // Classify an instruction byte
    function automatic lrc_op_e lrc_decode(input logic [7:0] b);
        lrc_op_e op;
        op = OP_NONE;
        if ((b & ONOFF_MASK) == ONOFF_CODE) begin
            op = OP_ONOFF;
        end else if ((b & PAGE_MASK) == PAGE_CODE) begin
            op = OP_PAGE;
        end else if ((b & LINE_MASK) == LINE_CODE) begin
            op = OP_LINE;
        end else if ((b & COL_MASK) == COL_CODE) begin
            op = OP_COL;
        end
        return op;
    endfunction

endpackage

//--- hdl/lrc_busy_timer.sv
// Down counter that holds the busy window after an accepted instruction.
// Assumes load is a one-cycle pulse in the core clock domain.
`timescale 1ns/1ns
`default_nettype none
module lrc_busy_timer #(
    parameter int CW = 4
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          nrst,
    // Control
    input  wire logic          load,
    input  wire logic [CW-1:0] load_val,
    // Status
    output logic               running
);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          running;
    } lrc_tmr_s;

    lrc_tmr_s tmr_reg;
    lrc_tmr_s tmr_next;

    // ------------------------------------------------------------------
    // Count down; running stays high for load_val cycles
    // ------------------------------------------------------------------
    always_comb begin
        tmr_next = tmr_reg;
        if (load) begin
            tmr_next.count   = load_val;
            tmr_next.running = (load_val != '0);
        end else if (tmr_reg.count != '0) begin
            tmr_next.count   = tmr_reg.count - 1'b1;
            tmr_next.running = (tmr_reg.count != {{(CW-1){1'b0}}, 1'b1});
        end else begin
            tmr_next.running = 1'b0;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign running = tmr_reg.running;

endmodule
`default_nettype wire

//--- hdl/lrc_cmd_port.sv
// Instruction decoder and register set of a dot-matrix LCD controller.
// Assumes host bus inputs are synchronous to core_clk and that the
// enable strobe stays high and low for several core clock cycles.
`timescale 1ns/1ns
`default_nettype none
module lrc_cmd_port #(
    parameter int TMR_W       = lrc_pkg::TMR_W,
    parameter int BUSY_CYCLES = lrc_pkg::BUSY_CYC
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // Host bus control
    input  wire logic              chip_select_first_n,
    input  wire logic              chip_select_second_n,
    input  wire logic              chip_select_third,
    input  wire logic              cmd_data_sel,
    input  wire logic              read_nwrite,
    input  wire logic              enable_strobe,
    // Host data bus, split into its three signals
    input  wire logic [7:0]        bus_data_in,
    output logic      [7:0]        bus_data_out,
    output logic                   bus_data_oe,
    // Register values for the display engine
    output lrc_pkg::lrc_disp_s     panel_regs,
    output logic                   busy
);

    // ------------------------------------------------------------------
    // State and decode signals
    // ------------------------------------------------------------------
    lrc_pkg::lrc_state_s state_reg;
    lrc_pkg::lrc_state_s state_next;

    logic            selected;
    logic            e_fall;
    logic            instr_wr;
    logic            accept;
    logic            stat_rd;
    logic            tmr_running;
    lrc_pkg::lrc_op_e op;

    // Chip is addressed only with all three selects active
    assign selected = !chip_select_first_n && !chip_select_second_n
                      && chip_select_third;

    // Falling edge of the enable strobe
    assign e_fall = state_reg.e_prev && !enable_strobe;

    // Instruction write from the values held while enable was high
    assign instr_wr = e_fall && state_reg.cap.sel
                      && !state_reg.cap.cmd_data_sel
                      && !state_reg.cap.read_nwrite;

    // Instructions only land while idle
    assign accept = instr_wr
                    && (state_reg.phase == lrc_pkg::PH_IDLE);

    // Selected status read with enable high
    assign stat_rd = selected && enable_strobe && read_nwrite
                     && !cmd_data_sel;

    assign op = lrc_pkg::lrc_decode(state_reg.cap.data);

    // ------------------------------------------------------------------
    // Busy window timer
    // ------------------------------------------------------------------
    lrc_busy_timer #(
        .CW       (TMR_W)
    ) u_busy_timer (
        .core_clk (core_clk),
        .nrst     (nrst),
        .load     (accept),
        .load_val (TMR_W'(BUSY_CYCLES)),
        .running  (tmr_running)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.e_prev = enable_strobe;

        // Track bus values while enable is high
        if (enable_strobe) begin
            state_next.cap.sel          = selected;
            state_next.cap.cmd_data_sel = cmd_data_sel;
            state_next.cap.read_nwrite  = read_nwrite;
            state_next.cap.data         = bus_data_in;
        end

        // Register loads from a taken instruction
        if (accept) begin
            case (op)
                lrc_pkg::OP_ONOFF: begin
                    state_next.disp.display_enable_reg =
                        state_reg.cap.data[0];
                end
                lrc_pkg::OP_LINE: begin
                    state_next.disp.first_line_reg =
                        state_reg.cap.data[5:0];
                end
                lrc_pkg::OP_PAGE: begin
                    state_next.disp.page_pointer_reg =
                        state_reg.cap.data[2:0];
                end
                lrc_pkg::OP_COL: begin
                    state_next.disp.column_pointer_reg =
                        state_reg.cap.data[5:0];
                end
                default: begin
                end
            endcase
        end

        // Idle and execute phases
        case (state_reg.phase)
            lrc_pkg::PH_IDLE: begin
                if (accept) begin
                    state_next.phase = lrc_pkg::PH_EXEC;
                end
            end
            lrc_pkg::PH_EXEC: begin
                if (!tmr_running) begin
                    state_next.phase = lrc_pkg::PH_IDLE;
                end
            end
            default: begin
                state_next.phase = lrc_pkg::PH_IDLE;
            end
        endcase

        // Status byte from the next register values
        state_next.controller_condition_reg = 8'h00;
        state_next.controller_condition_reg[lrc_pkg::ST_BUSY_BIT] =
            (state_next.phase == lrc_pkg::PH_EXEC);
        state_next.controller_condition_reg[lrc_pkg::ST_OFF_BIT] =
            !state_next.disp.display_enable_reg;
        state_next.controller_condition_reg[lrc_pkg::ST_RESET_BIT] = 1'h0;

        // Drive status only in a selected status read
        state_next.doe  = stat_rd;
        state_next.dout = stat_rd ? state_reg.controller_condition_reg
                                  : 8'h00;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg.phase <= lrc_pkg::PH_IDLE;
            state_reg.e_prev <= 1'h0;
            state_reg.cap <= '0;
            state_reg.disp.display_enable_reg <= lrc_pkg::DISP_EN_RST;
            state_reg.disp.first_line_reg <= lrc_pkg::LINE_RST;
            state_reg.disp.page_pointer_reg <= lrc_pkg::PAGE_RST;
            state_reg.disp.column_pointer_reg <= lrc_pkg::COL_RST;
            state_reg.controller_condition_reg <=
                lrc_pkg::STATUS_RST;
            state_reg.dout <= 8'h00;
            state_reg.doe <= 1'h0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign bus_data_out = state_reg.dout;
    assign bus_data_oe  = state_reg.doe;
    assign panel_regs   = state_reg.disp;
    assign busy =
        state_reg.controller_condition_reg[lrc_pkg::ST_BUSY_BIT];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_reset_values;
        @(posedge core_clk) disable iff (!nrst)
        $rose(nrst) |-> (state_reg.controller_condition_reg == 8'h20)
            && !panel_regs.display_enable_reg
            && (panel_regs.first_line_reg == 6'h00);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("register values after reset wrong");

    property p_onoff_load;
        @(posedge core_clk) disable iff (!nrst)
        accept && (state_reg.cap.data[7:1] == 7'h1F) |=>
            panel_regs.display_enable_reg == $past(state_reg.cap.data[0]);
    endproperty
    a_onoff_load: assert property (p_onoff_load)
        else $error("on/off instruction not applied");

    property p_line_load;
        @(posedge core_clk) disable iff (!nrst)
        accept && (state_reg.cap.data[7:6] == 2'h3) |=>
            panel_regs.first_line_reg == $past(state_reg.cap.data[5:0]);
    endproperty
    a_line_load: assert property (p_line_load)
        else $error("start line instruction not applied");

    property p_page_load;
        @(posedge core_clk) disable iff (!nrst)
        accept && (state_reg.cap.data[7:3] == 5'h17) |=>
            panel_regs.page_pointer_reg == $past(state_reg.cap.data[2:0]);
    endproperty
    a_page_load: assert property (p_page_load)
        else $error("page instruction not applied");

    property p_col_load;
        @(posedge core_clk) disable iff (!nrst)
        accept && (state_reg.cap.data[7:6] == 2'h1) |=>
            panel_regs.column_pointer_reg
                == $past(state_reg.cap.data[5:0]);
    endproperty
    a_col_load: assert property (p_col_load)
        else $error("column instruction not applied");

    property p_status_layout;
        @(posedge core_clk) disable iff (!nrst)
        (state_reg.controller_condition_reg[5]
            == !panel_regs.display_enable_reg)
        && (state_reg.controller_condition_reg[6] == 1'h0)
        && (state_reg.controller_condition_reg[3:0] == 4'h0);
    endproperty
    a_status_layout: assert property (p_status_layout)
        else $error("status byte layout wrong");

    // Busy clears one registered stage after the window runs out
    localparam int BUSY_LAST = BUSY_CYCLES + 2;

    property p_busy_hold;
        @(posedge core_clk) disable iff (!nrst)
        $fell(busy) |-> $past(busy, BUSY_CYCLES + 1)
            && !$past(busy, BUSY_CYCLES + 2);
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy window length wrong");

    property p_busy_end;
        @(posedge core_clk) disable iff (!nrst)
        accept |-> ##[1:BUSY_LAST] !busy;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy did not end");

    property p_ignore_busy;
        @(posedge core_clk) disable iff (!nrst)
        instr_wr && (state_reg.phase == lrc_pkg::PH_EXEC) |=>
            $stable(panel_regs);
    endproperty
    a_ignore_busy: assert property (p_ignore_busy)
        else $error("instruction taken while busy");

    property p_falling_edge;
        @(posedge core_clk) disable iff (!nrst)
        accept |-> $past(enable_strobe) && !enable_strobe;
    endproperty
    a_falling_edge: assert property (p_falling_edge)
        else $error("instruction taken off the falling edge");

    property p_drive_only_read;
        @(posedge core_clk) disable iff (!nrst)
        bus_data_oe |-> $past(selected && enable_strobe && read_nwrite
            && !cmd_data_sel)
            && (bus_data_out == $past(state_reg.controller_condition_reg));
    endproperty
    a_drive_only_read: assert property (p_drive_only_read)
        else $error("data bus driven outside a status read");

    // Main scenarios
    c_panel_on: cover property (@(posedge core_clk) disable iff (!nrst)
        accept && (op == lrc_pkg::OP_ONOFF) && state_reg.cap.data[0]);
    c_line_set: cover property (@(posedge core_clk) disable iff (!nrst)
        accept && (op == lrc_pkg::OP_LINE));
    c_read_busy: cover property (@(posedge core_clk) disable iff (!nrst)
        bus_data_oe && bus_data_out[7]);
    c_ignored: cover property (@(posedge core_clk) disable iff (!nrst)
        instr_wr && !accept);

endmodule
`default_nettype wire

//--- tb/lrc_host_model.sv
// Host microcontroller model driving the LCD command port bus.
// Assumes the bench calls its tasks; bus changes at falling clock edges.
`timescale 1ns/1ns
`default_nettype none
module lrc_host_model (
    // Clock
    input  wire logic       core_clk,
    // Device data bus side
    input  wire logic [7:0] bus_data_out,
    input  wire logic       bus_data_oe,
    // Host control lines
    output logic            chip_select_first_n,
    output logic            chip_select_second_n,
    output logic            chip_select_third,
    output logic            cmd_data_sel,
    output logic            read_nwrite,
    output logic            enable_strobe,
    // Resolved bus level
    output logic [7:0]      bus_wire
);
    logic       host_oe;
    logic [7:0] host_dout;
    logic [7:0] idle_pat = 8'hA5;

    // Undriven bus wanders every cycle
    always @(posedge core_clk) begin
        idle_pat <= ~idle_pat;
    end

    // Bus level from both drivers
    assign bus_wire = bus_data_oe ? bus_data_out :
                      (host_oe ? host_dout : idle_pat);

    // Idle bus at time zero
    initial begin
        {chip_select_first_n, chip_select_second_n, chip_select_third} =
            3'b110;
        {cmd_data_sel, read_nwrite, enable_strobe, host_oe} = 4'h0;
        host_dout = 8'h00;
    end

    // Raise enable with selects, kind and data
    task automatic bus_start(input logic [2:0] cs, input logic cd,
                             input logic rw, input logic [7:0] d);
        @(negedge core_clk);
        {chip_select_first_n, chip_select_second_n, chip_select_third} = cs;
        cmd_data_sel  = cd;
        read_nwrite   = rw;
        host_dout     = d;
        host_oe       = !rw;
        enable_strobe = 1'b1;
    endtask

    // Drop enable, then release after the taking edge
    task automatic bus_end();
        @(negedge core_clk);
        enable_strobe = 1'b0;
        @(negedge core_clk);
        {chip_select_first_n, chip_select_second_n, chip_select_third} =
            3'b110;
        host_oe = 1'b0;
    endtask

    // Instruction write, select low and write low
    task automatic write_instr(input logic [7:0] d);
        bus_start(3'b001, 1'b0, 1'b0, d);
        @(negedge core_clk);
        bus_end();
    endtask

    // Read cycle returning bus level and device drive
    task automatic bus_read(input logic [2:0] cs, input logic cd,
                            output logic [7:0] v, output logic oe);
        bus_start(cs, cd, 1'b1, 8'h00);
        repeat (3) @(negedge core_clk);
        v  = bus_wire;
        oe = bus_data_oe;
        bus_end();
    endtask

    // Status read
    task automatic read_status(output logic [7:0] v);
        logic oe;
        bus_read(3'b001, 1'b0, v, oe);
    endtask

    // Poll until not busy before the next instruction
    task automatic wait_idle();
        logic [7:0] v;
        for (int i = 0; i < 40; i++) begin
            read_status(v);
            if (v[7] === 1'b0) break;
        end
    endtask

    // Program the four writable registers after reset
    task automatic init_regs();
        write_instr(8'h3E);
        wait_idle();
        write_instr(8'hC0);
        wait_idle();
        write_instr(8'hB8);
        wait_idle();
        write_instr(8'h40);
        wait_idle();
    endtask
endmodule
`default_nettype wire

//--- tb/test_lrc_cmd_port.sv
// Self-checking bench for the LCD command port.
// Assumes the host model file is compiled first; busy time is shortened.
`timescale 1ns/1ns
`default_nettype none
module test_lrc_cmd_port;
    localparam int BUSY_TB = 6;

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] regs;
        logic [7:0]  status;
    } lrc_row_s;

    logic               core_clk;
    logic               nrst;
    logic               cs1_n;
    logic               cs2_n;
    logic               cs3;
    logic               cd;
    logic               rw;
    logic               en;
    logic [7:0]         bus_wire;
    logic [7:0]         dout;
    logic               doe;
    lrc_pkg::lrc_disp_s panel_regs;
    logic               busy;
    int                 num_errors;
    int                 samples_checked;
    int                 cycles;
    int                 n;
    logic [7:0]         v;
    logic               oe;
    lrc_row_s           rows [11];
    logic [3:0]         refused [4];

    lrc_cmd_port #(.TMR_W(4), .BUSY_CYCLES(BUSY_TB)) dut (
        .core_clk(core_clk), .nrst(nrst),
        .chip_select_first_n(cs1_n), .chip_select_second_n(cs2_n),
        .chip_select_third(cs3), .cmd_data_sel(cd), .read_nwrite(rw),
        .enable_strobe(en), .bus_data_in(bus_wire), .bus_data_out(dout),
        .bus_data_oe(doe), .panel_regs(panel_regs), .busy(busy));

    lrc_host_model host (
        .core_clk(core_clk), .bus_data_out(dout), .bus_data_oe(doe),
        .chip_select_first_n(cs1_n), .chip_select_second_n(cs2_n),
        .chip_select_third(cs3), .cmd_data_sel(cd), .read_nwrite(rw),
        .enable_strobe(en), .bus_wire(bus_wire));

    // Clock
    always #25 core_clk = ~core_clk;

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    // Count cycles that busy stays high
    task automatic busy_len(output int k);
        k = 0;
        while (busy === 1'b1 && k < 50) begin
            k++;
            @(negedge core_clk);
        end
    endtask

    // Main sequence
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        cycles = 0;
        rows = '{
            '{8'hFF, 16'hFE00, 8'h00}, '{8'hC0, 16'h8000, 8'h00},
            '{8'hBF, 16'h81C0, 8'h00}, '{8'hB8, 16'h8000, 8'h00},
            '{8'h7F, 16'h803F, 8'h00}, '{8'h40, 16'h8000, 8'h00},
            '{8'h3E, 16'h0000, 8'h20}, '{8'h3F, 16'h8000, 8'h00},
            '{8'hE5, 16'hCA00, 8'h00}, '{8'h00, 16'hCA00, 8'h00},
            '{8'hB3, 16'hCA00, 8'h00}};
        refused = '{4'b1010, 4'b0110, 4'b0000, 4'b0011};
        repeat (3) @(negedge core_clk);
        check(panel_regs.display_enable_reg, 16'h0000);
        check(panel_regs.first_line_reg, 16'h0000);
        check(doe, 16'h0000);
        nrst = 1'b1;
        @(negedge core_clk);
        check(busy, 16'h0000);
        host.read_status(v);
        check(v, 16'h0020);
        host.init_regs();
        // Write taken only when enable falls
        host.bus_start(3'b001, 1'b0, 1'b0, 8'h3F);
        repeat (4) @(negedge core_clk);
        check({busy, panel_regs.display_enable_reg}, 16'h0000);
        host.bus_end();
        // Count from the first falling clock edge with busy up
        busy_len(n);
        check(panel_regs.display_enable_reg, 16'h0001);
        check(16'(n), 16'(BUSY_TB + 1));
        // Table of instruction codes
        foreach (rows[i]) begin
            host.write_instr(rows[i].code);
            host.wait_idle();
            check(panel_regs, rows[i].regs);
            host.read_status(v);
            check(v, rows[i].status);
        end
        // Instruction during busy is dropped
        host.write_instr(8'h3E);
        host.write_instr(8'hC5);
        host.wait_idle();
        check(panel_regs, 16'h4A00);
        // Status read while busy
        host.write_instr(8'h3F);
        host.read_status(v);
        check(v, 16'h0080);
        host.wait_idle();
        // Unselected and data cycles are ignored
        foreach (refused[i]) begin
            host.bus_start(refused[i][3:1], refused[i][0], 1'b0, 8'hC7);
            @(negedge core_clk);
            host.bus_end();
            @(negedge core_clk);
            check(busy, 16'h0000);
            host.bus_read(refused[i][3:1], refused[i][0], v, oe);
            check(oe, 16'h0000);
        end
        check(panel_regs, 16'hCA00);
        // Second reset in mid-run
        @(negedge core_clk);
        nrst = 1'b0;
        @(negedge core_clk);
        check({panel_regs.display_enable_reg, panel_regs.first_line_reg},
              16'h0000);
        nrst = 1'b1;
        host.read_status(v);
        check(v, 16'h0020);
        end_sim();
    end
endmodule
`default_nettype wire
